// file: testbench/rcdd_host_model.sv
// host model that shifts words into the three-wire serial port
`timescale 1ns/1ps

module rcdd_host_model (
  // clock the host paces itself by
  input  wire logic ref_clk,
  // serial port pins
  output logic      serialClk,
  output logic      serialData,
  output logic      latch_strobe
);
  // ----------------------------------------------------------------
  // idle pins at time zero
  // ----------------------------------------------------------------
  initial begin
    serialClk    = 1'b0;
    serialData   = 1'b0;
    latch_strobe = 1'b0;
  end

  // ----------------------------------------------------------------
  // one word, msb first; four cycles a level so the sync sees each edge
  // ----------------------------------------------------------------
  task automatic write_word(input logic [23:0] word);
    for (int i = 23; i >= 0; i--) begin
      @(negedge ref_clk);
      serialClk  <= 1'b0;
      serialData <= word[i];
      repeat (4) @(negedge ref_clk);
      serialClk  <= 1'b1;
      repeat (3) @(negedge ref_clk);
    end
    @(negedge ref_clk);
    serialClk    <= 1'b0;
    serialData   <= ~word[0];     // released line shows no stale bit
    repeat (4) @(negedge ref_clk);
    latch_strobe <= 1'b1;         // strobe only with the clock idle
    repeat (4) @(negedge ref_clk);
    latch_strobe <= 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask : write_word
endmodule : rcdd_host_model

// file: testbench/rcdd_ref_clock_tb_top.sv
// self-checking bench for the reference clock divider block
`timescale 1ns/1ps

module rcdd_ref_clock_tb_top;
  import rcdd_pkg::*;
  // ----------------------------------------------------------------
  // signals, counters
  // ----------------------------------------------------------------
  logic      ref_clk, srst, powerGate, serialClk, serialData, latch_strobe;
  logic      divided_ref_out, pfdRefTick, xtalRun, serialReady;
  rcdd_cfg_t cfg;
  int        errTotal = 0;
  int        samplesChecked = 0;
  int        hi, lo, gap;
  logic [3:0] auxTab [3] = '{4'h1, 4'h3, 4'hF};  // ratios 2, 6, 30
  logic [3:0] rTab [3]   = '{4'hF, 4'h2, 4'h5};

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  rcdd_ref_clock i_rcdd_ref_clock (.ref_clk(ref_clk), .srst(srst), .powerGate(powerGate),
    .serialClk(serialClk), .serialData(serialData), .latch_strobe(latch_strobe), .cfg(cfg),
    .divided_ref_out(divided_ref_out), .pfdRefTick(pfdRefTick), .xtalRun(xtalRun),
    .serialReady(serialReady));
  rcdd_host_model i_rcdd_host_model (.ref_clk(ref_clk), .serialClk(serialClk),
    .serialData(serialData), .latch_strobe(latch_strobe));

  // ----------------------------------------------------------------
  // compare, verdict, bounded waits
  // ----------------------------------------------------------------
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d mismatches %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic wait_aux(input logic lvl);
    for (int n = 0; n < 100 && divided_ref_out !== lvl; n++) @(negedge ref_clk);
  endtask : wait_aux

  // lengths of one high and one low run of the aux clock
  task automatic aux_runs();
    wait_aux(1'b0);
    wait_aux(1'b1);
    hi = 0;
    lo = 0;
    for (; divided_ref_out === 1'b1 && hi < 100; hi++) @(negedge ref_clk);
    for (; divided_ref_out === 1'b0 && lo < 100; lo++) @(negedge ref_clk);
  endtask : aux_runs

  // cycles from one detector tick to the next
  task automatic tick_gap();
    for (int n = 0; n < 40 && pfdRefTick !== 1'b1; n++) @(negedge ref_clk);
    gap = 0;
    do begin
      @(negedge ref_clk);
      gap++;
    end while (pfdRefTick !== 1'b1 && gap < 40);
  endtask : tick_gap

  function automatic logic [23:0] ref_word(logic [3:0] aux, logic off, logic [3:0] r);
    return {2'b00, aux, off, r, 11'h5A5, SEL_REF};
  endfunction : ref_word

  // ----------------------------------------------------------------
  // watchdog: the sequence needs well under 10k cycles
  // ----------------------------------------------------------------
  initial begin
    #100_000;
    errTotal++;
    close_out();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    srst      = 1'b1;
    powerGate = 1'b1;
    repeat (4) @(negedge ref_clk);
    srst = 1'b0;
    check(cfg, CFG_RESET);
    check(xtalRun, 1'b1);
    for (int n = 0; n < 20 && serialReady !== 1'b1; n++) @(negedge ref_clk);
    aux_runs();
    check({hi, lo}, {32'd8, 32'd8});
    tick_gap();
    check(gap, 1);
    $display("test defaults done");
    // aux and reference ratios, applied at the next terminal count
    for (int k = 0; k < 3; k++) begin
      i_rcdd_host_model.write_word(ref_word(auxTab[k], 1'b0, rTab[k]));
      check(cfg.refWord, ref_word(auxTab[k], 1'b0, rTab[k]));
      aux_runs();
      aux_runs();
      check({hi, lo}, {28'd0, auxTab[k], 28'd0, auxTab[k]});
      tick_gap();
      tick_gap();
      check(gap, rTab[k]);
    end
    $display("test ratios done");
    // buffer off holds the output low
    i_rcdd_host_model.write_word(24'h00_18C3);
    repeat (40) @(negedge ref_clk);
    hi = 0;
    repeat (40) begin
      @(negedge ref_clk);
      if (divided_ref_out !== 1'b0) hi++;
    end
    check(hi, 0);
    i_rcdd_host_model.write_word(FUNC_RESET);
    aux_runs();
    check({hi, lo}, {28'd0, auxTab[2], 28'd0, auxTab[2]});
    $display("test buffer done");
    // zero fields fall back to ratio 2 and divide by one
    i_rcdd_host_model.write_word(ref_word(4'h0, 1'b0, 4'h0));
    aux_runs();
    aux_runs();
    check({hi, lo}, {32'd1, 32'd1});
    tick_gap();
    tick_gap();
    check(gap, 1);
    $display("test zero fields done");
    // integer field limits and the other latches
    i_rcdd_host_model.write_word({2'b11, 8'h0A, 12'hABC, SEL_DIV});
    check(cfg.divWord, {2'b11, 8'h1F, 12'hABC, SEL_DIV});
    i_rcdd_host_model.write_word({2'b00, 8'hFF, 12'h001, SEL_DIV});
    check(cfg.divWord, {2'b00, 8'hFF, 12'h001, SEL_DIV});
    i_rcdd_host_model.write_word(24'h12_3456);
    check(cfg.modWord, 24'h12_3456);
    $display("test latches done");
    // external reference, then power loss
    i_rcdd_host_model.write_word(ref_word(4'h8, 1'b1, 4'h1));
    repeat (4) @(negedge ref_clk);
    check(xtalRun, 1'b0);
    i_rcdd_host_model.write_word(ref_word(4'h8, 1'b0, 4'h1));
    repeat (4) @(negedge ref_clk);
    check(xtalRun, 1'b1);
    powerGate = 1'b0;
    repeat (6) @(negedge ref_clk);
    check({cfg, serialReady, xtalRun}, {CFG_RESET, 2'b00});
    i_rcdd_host_model.write_word(24'h00_0003);
    powerGate = 1'b1;
    for (int n = 0; n < 20 && serialReady !== 1'b1; n++) @(negedge ref_clk);
    check(cfg, CFG_RESET);
    $display("test power done");
    close_out();
  end
endmodule : rcdd_ref_clock_tb_top

// file: verilog/rcdd_pkg.sv
// constants, reset words and field layout for the reference clock divider block
package rcdd_pkg;

  // ----------------------------------------------------------------
  // latch selection codes (two lowest bits of every word)
  // ----------------------------------------------------------------
  localparam logic [1:0]  SEL_REF          = 2'h0;         // reference_setup
  localparam logic [1:0]  SEL_DIV          = 2'h1;         // divider_setup
  localparam logic [1:0]  SEL_MOD          = 2'h2;         // modulation_setup
  localparam logic [1:0]  SEL_FUNC         = 2'h3;         // function_setup

  // ----------------------------------------------------------------
  // power-up contents of the four latches
  // ----------------------------------------------------------------
  localparam logic [23:0] REF_RESET        = 24'h20_2000;  // aux field 8, ref divide 1
  localparam logic [23:0] DIV_RESET        = 24'h20_2001;  // int 128, frac 2048
  localparam logic [23:0] MOD_RESET        = 24'h80_0602;
  localparam logic [23:0] FUNC_RESET       = 24'h00_18D3;  // output buffer enabled

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          SEL_MSB          = 1;            // latch_select_bits
  localparam int          SEL_LSB          = 0;
  localparam int          AUX_MSB          = 21;           // aux divide, bits 21..18 of reference_setup
  localparam int          AUX_LSB          = 18;
  localparam int          XOE_BIT          = 17;           // crystal_osc_off
  localparam int          RDIV_MSB         = 16;           // 4-bit reference divide
  localparam int          RDIV_LSB         = 13;
  localparam int          CORR_MSB         = 12;           // signed frequency correction
  localparam int          CORR_LSB         = 2;
  localparam int          LDP_BIT          = 23;           // lock_precision
  localparam int          V1_BIT           = 22;           // low_band_select
  localparam int          NINT_MSB         = 21;           // 8-bit integer divide
  localparam int          NINT_LSB         = 14;
  localparam int          NFRAC_MSB        = 13;           // 12-bit fractional divide
  localparam int          NFRAC_LSB        = 2;
  localparam int          BUF_EN_BIT       = 4;            // divided_ref_out buffer enable

  // ----------------------------------------------------------------
  // divider limits and reset states
  // ----------------------------------------------------------------
  localparam logic [7:0]  NINT_MIN         = 8'h1F;        // smallest integer ratio, 31
  localparam logic [3:0]  HALF_MIN         = 4'h1;         // half period of ratio 2
  localparam logic [3:0]  AUX_HALF_RESET   = 4'h8;         // half period of ratio 16
  localparam logic [3:0]  RDIV_MIN         = 4'h1;         // reference divide of 1
  localparam logic [3:0]  CNT_RESET        = 4'h0;
  localparam logic        XTAL_RUN_RESET   = 1'b1;         // oscillator runs from power-up
  localparam logic        BUF_EN_RESET     = 1'b1;

  // ----------------------------------------------------------------
  // carrier for the four latched words
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [23:0] funcWord;
    logic [23:0] modWord;
    logic [23:0] divWord;
    logic [23:0] refWord;
  } rcdd_cfg_t;

  localparam rcdd_cfg_t CFG_RESET = '{FUNC_RESET, MOD_RESET, DIV_RESET, REF_RESET};

endpackage : rcdd_pkg

// file: verilog/rcdd_ref_clock.sv
// serial register latches, aux clock divider and reference divider
//
// Contract
// - integer field 8 bits, ratio 31..255, fraction 12
// - signed correction below ref divide, select bits lowest
// - oscillator runs unless off bit, stops unpowered
// - aux output is divided reference, equal halves
// - aux ratio even 2..30 from bits 21..18
// - aux divider defaults to divide by sixteen
// - buffer bit enables aux output, default high
// - reference divide 4 bits, 1..15, feeds detector
// - reference divide defaults to one
// - strobe rise copies shift word to selected latch
// - power gate low clears latches, blocks writes
`timescale 1ns/1ps

module rcdd_ref_clock (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              srst,
  // pins from the host side
  input  wire logic              powerGate,
  input  wire logic              serialClk,
  input  wire logic              serialData,
  input  wire logic              latch_strobe,
  // latched configuration
  output rcdd_pkg::rcdd_cfg_t    cfg,
  // clocks and status
  output logic                   divided_ref_out,
  output logic                   pfdRefTick,
  output logic                   xtalRun,
  output logic                   serialReady
);
  import rcdd_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0]  pinMeta;      // first stage, read only by pinSync
  logic [3:0]  pinSync;      // second stage
  logic        sclkPrev;     // edge history of serial clock
  logic        latchPrev;    // edge history of strobe

  // pins ride the same two stages so data stays aligned to its clock edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pinMeta   <= 4'h0;
      pinSync   <= 4'h0;
      sclkPrev  <= 1'b0;
      latchPrev <= 1'b0;
    end else begin
      pinMeta   <= {powerGate, serialClk, serialData, latch_strobe};
      pinSync   <= pinMeta;
      sclkPrev  <= pinSync[2];
      latchPrev <= pinSync[0];
    end
  end

  wire powerOn   = pinSync[3];                 // internal supply present
  wire clearAll  = srst | ~powerOn;            // unpowered port is held in reset
  wire sclkRise  = pinSync[2] & ~sclkPrev;     // one bit per serial clock
  wire dataBit   = pinSync[1];
  wire latchRise = pinSync[0] & ~latchPrev;

  // ----------------------------------------------------------------
  // shift register and latches
  // ----------------------------------------------------------------
  logic [23:0] shiftReg;     // 24-bit serial word, msb arrives first

  // new bit enters at the bottom so the first bit ends at the top
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      shiftReg <= 24'h00_0000;
    end else if (sclkRise) begin
      shiftReg <= {shiftReg[22:0], dataBit};
    end
  end

  // an integer ratio below the minimum is raised to it
  wire [1:0]  latchSel   = shiftReg[SEL_MSB:SEL_LSB];
  wire [7:0]  shiftInt   = shiftReg[NINT_MSB:NINT_LSB];
  wire [7:0]  safeInt    = (shiftInt < NINT_MIN) ? NINT_MIN : shiftInt;
  wire [23:0] divLatched = {shiftReg[23:NINT_MSB+1], safeInt, shiftReg[NINT_LSB-1:0]};

  // strobe rise copies the word into the latch named by its low bits
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      cfg <= CFG_RESET;
    end else if (latchRise) begin
      case (latchSel)
        SEL_REF:  cfg.refWord  <= shiftReg;
        SEL_DIV:  cfg.divWord  <= divLatched;
        SEL_MOD:  cfg.modWord  <= shiftReg;
        SEL_FUNC: cfg.funcWord <= shiftReg;
        default:  cfg          <= cfg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // oscillator control and status
  // ----------------------------------------------------------------
  // external reference use relies on the host setting the off bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      xtalRun     <= XTAL_RUN_RESET;
      serialReady <= 1'b0;
    end else begin
      xtalRun     <= powerOn & ~cfg.refWord[XOE_BIT];
      serialReady <= powerOn;
    end
  end

  // ----------------------------------------------------------------
  // aux clock divider
  // ----------------------------------------------------------------
  logic [3:0]  auxCnt;       // position within half period
  logic [3:0]  auxHalf;      // half period in use
  logic        auxPhase;     // free running divided phase
  logic        auxEn;        // buffer enable adopted at a rising start

  wire [3:0] auxField   = cfg.refWord[AUX_MSB:AUX_LSB];
  // ratio is twice the field; a zero field falls back to ratio 2
  wire [3:0] auxHalfReq = (auxField == 4'h0) ? HALF_MIN : auxField;
  wire       auxTerm    = (auxCnt == auxHalf - 4'h1);
  wire       bufReq     = cfg.funcWord[BUF_EN_BIT];
  wire       next_phase = auxTerm ? ~auxPhase : auxPhase;
  // enable only changes where a high half would start, so no runt appears
  wire       next_en    = (auxTerm & ~auxPhase) ? bufReq : auxEn;

  // equal high and low halves, ratio taken only at terminal count
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      auxCnt          <= CNT_RESET;
      auxHalf         <= AUX_HALF_RESET;
      auxPhase        <= 1'b0;
      auxEn           <= BUF_EN_RESET;
      divided_ref_out <= 1'b0;
    end else begin
      auxCnt          <= auxTerm ? CNT_RESET : auxCnt + 4'h1;
      auxHalf         <= auxTerm ? auxHalfReq : auxHalf;
      auxPhase        <= next_phase;
      auxEn           <= next_en;
      divided_ref_out <= next_phase & next_en;
    end
  end

  // ----------------------------------------------------------------
  // reference divider for the phase detector
  // ----------------------------------------------------------------
  logic [3:0]  rCnt;         // cycles since last tick
  logic [3:0]  rRatio;       // ratio in use

  wire [3:0] rField = cfg.refWord[RDIV_MSB:RDIV_LSB];
  wire [3:0] rReq   = (rField == 4'h0) ? RDIV_MIN : rField;
  wire       rTerm  = (rCnt == rRatio - 4'h1);

  // one tick per ratio cycles; ratio one ticks every cycle
  always_ff @(posedge ref_clk) begin
    if (clearAll) begin
      rCnt       <= CNT_RESET;
      rRatio     <= RDIV_MIN;
      pfdRefTick <= 1'b0;
    end else begin
      rCnt       <= rTerm ? CNT_RESET : rCnt + 4'h1;
      rRatio     <= rTerm ? rReq : rRatio;
      pfdRefTick <= rTerm;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  // power loss acts as a second reset: it throws phases and counters back to
  // their start values off any terminal count, so the phase checks skip that edge
  // the gating checks look at the latched enable, not at the gated copy of it,
  // so a broken enable path cannot satisfy them by construction
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_int_floor: assert property (cfg.divWord[NINT_MSB:NINT_LSB] >= NINT_MIN)
    else $error("integer ratio below minimum");
  a_xtal_stops: assert property (!powerOn |=> !xtalRun)
    else $error("oscillator running while unpowered");
  a_aux_toggle: assert property ($changed(auxPhase) && !$past(clearAll)
    |-> $past(auxCnt) == $past(auxHalf) - 4'h1)
    else $error("aux phase toggled off terminal count");
  a_aux_even: assert property (auxHalf >= HALF_MIN && auxHalf == $past(auxHalf)
    || $past(auxTerm) || $past(clearAll))
    else $error("aux half period invalid");
  a_aux_default: assert property ($fell(clearAll) |-> auxHalf == AUX_HALF_RESET && rRatio == RDIV_MIN)
    else $error("divider defaults wrong after power-up");
  a_out_gated: assert property ($rose(divided_ref_out) |-> $past(cfg.funcWord[BUF_EN_BIT]))
    else $error("aux output rose while buffer disabled");
  a_r_tick: assert property (pfdRefTick |-> $past(rCnt) == $past(rRatio) - 4'h1)
    else $error("reference tick off terminal count");
  a_latch_func: assert property (latchRise && !clearAll && latchSel == SEL_FUNC |=> cfg.funcWord == $past(shiftReg))
    else $error("function latch missed");
  a_power_clear: assert property (!powerOn |=> cfg == CFG_RESET && shiftReg == 24'h00_0000)
    else $error("latches kept while unpowered");
  a_no_runt: assert property ($rose(divided_ref_out) |-> divided_ref_out [*1]
    ##1 (divided_ref_out || auxTerm || $past(clearAll)))
    else $error("runt pulse on aux output");
  // a new reference ratio must never cut a count short
  a_r_adopt: assert property (rRatio != $past(rRatio) |-> $past(rTerm) || $past(clearAll))
    else $error("reference ratio changed off terminal count");
  // with the off bit latched the oscillator must stop on the next edge
  a_xtal_off: assert property (powerOn && cfg.refWord[XOE_BIT] |=> !xtalRun)
    else $error("oscillator running with off bit set");

  c_latch_ref: cover property (latchRise && latchSel == SEL_REF && !clearAll);
  c_latch_div: cover property (latchRise && latchSel == SEL_DIV && !clearAll);
  c_aux_rise: cover property ($rose(divided_ref_out));
  c_aux_off: cover property ($fell(auxEn));
  c_ref_tick: cover property (pfdRefTick && rRatio == 4'hF);

endmodule : rcdd_ref_clock
